// ==== hw/dtmc_timer.sv ====
// dtmc_timer: register file and counters of the dual 16-bit timer.
// assumes a single-cycle strobe register port; pins are asynchronous.
//
// The register addresses and the address-and-strobe port were left to the implementer.

// Functional notes
// - counter one value readable and writable
// - counter two value readable and writable
// - reload/capture one readable and writable
// - reload/capture two readable and writable
// - reset leaves counters and reloads alone
// - reset clears mode control
// - two-bit field selects four modes
// - dual capture: pin A edge presets one
// - other modes: pin A is PWM output
// - pin A disabled: ignored, undriven
// - pin B edge presets one or two
// - pin B enable inert in modes 0,2
// - output level bit tracks PWM pin
// - software write beats hardware update; pending bits: a hardware set beats a clear write
// - output level inert while pin A input
// - global disable stops all counting
// - disabled: counter, reload, pending writes ignored
// - disabled: prescaler and pending held zero
// - disabled: pin A released as input
// - three-bit clock source per counter
// - prescaled clock is divide by value+1
// - pending cleared only via clear register, disable or reset
module dtmc_timer (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic [4:0] regAddr,
  input wire logic [15:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [15:0] regRdata,
  input wire logic pinAIn,
  output logic pinAOut,
  output logic pinAOe,
  input wire logic pinBIn,
  input wire logic slowTick,
  output logic [3:0] pendingFlags
);
  logic [15:0] counterOne;
  logic [15:0] counterTwo;
  logic [15:0] reloadOne;
  logic [15:0] reloadTwo;
  logic [7:0] modeControl;
  logic [4:0] prescalerDivisor;
  logic [5:0] clockSelect;
  logic [7:0] intControl;
  logic [1:0] mode;
  logic timerOn;
  logic enA;
  logic enB;
  logic preTick;
  logic pinALevel;
  logic pinAEdge;
  logic pinBLevel;
  logic pinBEdge;
  logic presetAOne;
  logic presetBOne;
  logic presetBTwo;
  logic stepOne;
  logic stepTwo;
  logic wrCounterOne;
  logic wrCounterTwo;
  logic wrReloadOne;
  logic wrReloadTwo;
  logic wrMode;
  logic wrIntCtl;
  logic wrClear;
  logic pwmActive;
  logic hwToggle;
  logic underflowOne;
  logic underflowTwo;
  logic [3:0] hwPendSet;

  assign mode = modeControl[dtmc_pkg::MODE_LSB +: 2];
  assign timerOn = modeControl[dtmc_pkg::GLOBAL_EN_BIT];
  assign enA = modeControl[dtmc_pkg::EN_A_BIT];
  assign enB = modeControl[dtmc_pkg::EN_B_BIT];

  assign wrMode = regWrite && regAddr == dtmc_pkg::OFF_MODE_CONTROL;
  assign wrCounterOne = regWrite && timerOn &&
    regAddr == dtmc_pkg::OFF_COUNTER_ONE;
  assign wrCounterTwo = regWrite && timerOn &&
    regAddr == dtmc_pkg::OFF_COUNTER_TWO;
  assign wrReloadOne = regWrite && timerOn &&
    regAddr == dtmc_pkg::OFF_RELOAD_ONE;
  assign wrReloadTwo = regWrite && timerOn &&
    regAddr == dtmc_pkg::OFF_RELOAD_TWO;
  assign wrIntCtl = regWrite && regAddr == dtmc_pkg::OFF_INT_CONTROL;
  assign wrClear = regWrite && regAddr == dtmc_pkg::OFF_PEND_CLEAR;

  dtmc_prescaler prescaler (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .clear(!timerOn),
    .divisor(prescalerDivisor),
    .tick(preTick)
  );

  dtmc_pin_sync syncA (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pinIn(pinAIn),
    .risePolarity(modeControl[dtmc_pkg::POL_A_BIT]),
    .level(pinALevel),
    .activeEdge(pinAEdge)
  );

  dtmc_pin_sync syncB (
    .core_clk(core_clk),
    .reset_n(reset_n),
    .pinIn(pinBIn),
    .risePolarity(modeControl[dtmc_pkg::POL_B_BIT]),
    .level(pinBLevel),
    .activeEdge(pinBEdge)
  );

  // pin A preset only in dual capture
  assign presetAOne = timerOn && enA && pinAEdge &&
    mode == dtmc_pkg::MODE_DUAL_CAPTURE;
  // pin B preset target by mode
  assign presetBOne = timerOn && enB && pinBEdge &&
    mode == dtmc_pkg::MODE_DUAL_CAPTURE;
  // no pin B preset in modes 0 and 2
  assign presetBTwo = timerOn && enB && pinBEdge &&
    mode == dtmc_pkg::MODE_SINGLE_CAPTURE;

  function automatic logic src_step(input logic [2:0] sel,
                                    input logic pre,
                                    input logic slow,
                                    input logic edgeB,
                                    input logic levelB,
                                    input logic polB);
    logic r;
    r = 1'b0;
    unique case (sel)
      dtmc_pkg::SRC_STOPPED: r = 1'b0;
      dtmc_pkg::SRC_PRESCALED: r = pre;
      dtmc_pkg::SRC_PIN_EVENT: r = edgeB;
      dtmc_pkg::SRC_PULSE_ACC: r = pre && (levelB == polB);
      dtmc_pkg::SRC_SLOW: r = slow;
      default: r = 1'b0;
    endcase
    return r;
  endfunction : src_step

  assign stepOne = timerOn && src_step(
    clockSelect[dtmc_pkg::SEL_ONE_LSB +: 3], preTick, slowTick,
    pinBEdge, pinBLevel, modeControl[dtmc_pkg::POL_B_BIT]);
  assign stepTwo = timerOn && src_step(
    clockSelect[dtmc_pkg::SEL_TWO_LSB +: 3], preTick, slowTick,
    pinBEdge, pinBLevel, modeControl[dtmc_pkg::POL_B_BIT]);

  assign underflowOne = stepOne && counterOne == 16'h0000;
  assign underflowTwo = stepTwo && counterTwo == 16'h0000;

  // no reset term: counters start unknown
  // counter one: write, preset, count down
  always_ff @(posedge core_clk) begin
    if (wrCounterOne) begin
      counterOne <= regWdata;
    end else if (presetAOne || presetBOne) begin
      counterOne <= dtmc_pkg::PRESET_VALUE;
    end else if (underflowOne && mode != dtmc_pkg::MODE_DUAL_CAPTURE) begin
      counterOne <= reloadOne;
    end else if (stepOne) begin
      counterOne <= counterOne - 16'h0001;
    end
  end

  // counter two: write, preset, count down
  always_ff @(posedge core_clk) begin
    if (wrCounterTwo) begin
      counterTwo <= regWdata;
    end else if (presetBTwo) begin
      counterTwo <= dtmc_pkg::PRESET_VALUE;
    end else if (underflowTwo) begin
      counterTwo <= reloadTwo;
    end else if (stepTwo) begin
      counterTwo <= counterTwo - 16'h0001;
    end
  end

  // reload one, captured on pin A in capture mode
  always_ff @(posedge core_clk) begin
    if (wrReloadOne) begin
      reloadOne <= regWdata;
    end else if (presetAOne) begin
      reloadOne <= counterOne;
    end
  end

  // reload two, captured on pin B in capture modes
  always_ff @(posedge core_clk) begin
    if (wrReloadTwo) begin
      reloadTwo <= regWdata;
    end else if (presetBOne) begin
      reloadTwo <= counterOne;
    end else if (presetBTwo) begin
      reloadTwo <= counterTwo;
    end
  end

  // PWM toggles on counter one underflow
  assign pwmActive = timerOn && enA && mode != dtmc_pkg::MODE_DUAL_CAPTURE;
  assign hwToggle = pwmActive && underflowOne;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      modeControl <= dtmc_pkg::MODE_CONTROL_RESET;
    end else if (wrMode) begin
      modeControl <= regWdata[7:0];
    end else if (hwToggle) begin
      modeControl[dtmc_pkg::OUT_A_BIT] <= !modeControl[dtmc_pkg::OUT_A_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prescalerDivisor <= dtmc_pkg::PRESCALER_RESET;
    end else if (!timerOn) begin
      prescalerDivisor <= dtmc_pkg::PRESCALER_RESET;
    end else if (regWrite && regAddr == dtmc_pkg::OFF_PRESCALER) begin
      prescalerDivisor <= regWdata[4:0];
    end
  end

  // clock select survives a disable; the prescaler and pending bits are cleared
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      clockSelect <= dtmc_pkg::CLOCK_SELECT_RESET;
    end else if (regWrite && regAddr == dtmc_pkg::OFF_CLOCK_SELECT) begin
      clockSelect <= regWdata[5:0];
    end
  end

  // from bit 0 up: underflow one, pin A, pin B, underflow two
  assign hwPendSet = {underflowTwo, presetBOne || presetBTwo,
                      presetAOne, underflowOne};

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      intControl <= dtmc_pkg::INT_CONTROL_RESET;
    end else begin
      if (wrIntCtl) begin
        intControl[7:4] <= regWdata[7:4];
      end
      if (!timerOn) begin
        intControl[3:0] <= 4'h0;
      end else begin
        intControl[3:0] <= (intControl[3:0] &
          ~(wrClear ? regWdata[3:0] : 4'h0)) | hwPendSet |
          (wrIntCtl ? regWdata[3:0] : 4'h0);
      end
    end
  end

  assign pendingFlags = intControl[3:0];

  // input use and disable release pin
  assign pinAOe = pwmActive;
  assign pinAOut = pwmActive && modeControl[dtmc_pkg::OUT_A_BIT];

  // register read mux, one cycle latency
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdata <= 16'h0000;
    end else if (regRead) begin
      unique case (regAddr)
        dtmc_pkg::OFF_COUNTER_ONE: regRdata <= counterOne;
        dtmc_pkg::OFF_COUNTER_TWO: regRdata <= counterTwo;
        dtmc_pkg::OFF_RELOAD_ONE: regRdata <= reloadOne;
        dtmc_pkg::OFF_RELOAD_TWO: regRdata <= reloadTwo;
        dtmc_pkg::OFF_MODE_CONTROL: regRdata <= {8'h00, modeControl};
        dtmc_pkg::OFF_PRESCALER: regRdata <= {11'h000, prescalerDivisor};
        dtmc_pkg::OFF_CLOCK_SELECT: regRdata <= {10'h000, clockSelect};
        dtmc_pkg::OFF_INT_CONTROL: regRdata <= {8'h00, intControl};
        dtmc_pkg::OFF_PEND_CLEAR: regRdata <= dtmc_pkg::PEND_CLEAR_READ;
        default: regRdata <= dtmc_pkg::UNMAPPED_READ;
      endcase
    end
  end

  a_reset_mode: assert property (@(posedge core_clk)
    $rose(reset_n) |-> modeControl == dtmc_pkg::MODE_CONTROL_RESET)
    else $error("mode control not cleared by reset");
  // counters start unknown; watches disabled writes to counter one and reload one only
  a_disabled_write: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    !timerOn && regWrite && (regAddr == dtmc_pkg::OFF_COUNTER_ONE ||
    regAddr == dtmc_pkg::OFF_RELOAD_ONE) |=>
    $stable(counterOne) && $stable(reloadOne))
    else $error("data register changed while disabled");
  a_disabled_count: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    !timerOn |-> !stepOne && !stepTwo && !preTick)
    else $error("counter stepped while disabled");
  a_pend_zero: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    !timerOn |=> intControl[3:0] == 4'h0)
    else $error("pending bits not held at zero");
  a_pin_release: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    (!timerOn || !enA || mode == dtmc_pkg::MODE_DUAL_CAPTURE) |-> !pinAOe)
    else $error("pin A driven while it should be input");
  a_preset_one: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    presetAOne && !wrCounterOne |=> counterOne == dtmc_pkg::PRESET_VALUE)
    else $error("pin A edge did not preset counter one");
  a_preset_two: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    presetBTwo && !wrCounterTwo |=> counterTwo == dtmc_pkg::PRESET_VALUE)
    else $error("pin B edge did not preset counter two");
  a_sw_wins: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    wrMode && hwToggle |=> modeControl == $past(regWdata[7:0]))
    else $error("software write lost to hardware");
  a_pend_sticky: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    timerOn && pendingFlags[0] && !wrClear ##1 timerOn |-> pendingFlags[0])
    else $error("pending bit dropped without clear");
  a_pwm_toggle: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    hwToggle && !wrMode |=> modeControl[dtmc_pkg::OUT_A_BIT] !=
    $past(modeControl[dtmc_pkg::OUT_A_BIT]))
    else $error("output level did not follow underflow");
endmodule : dtmc_timer

// ==== common/dtmc_pkg.sv ====
// dtmc_pkg: register map, field positions and encodings of the dual timer.
// assumes a byte-addressed register port with 16-bit data lanes.
package dtmc_pkg;
  localparam int ADDR_W = 5;
  localparam int DATA_W = 16;
  localparam logic [4:0] OFF_COUNTER_ONE = 5'h00;
  localparam logic [4:0] OFF_RELOAD_ONE = 5'h02;
  localparam logic [4:0] OFF_RELOAD_TWO = 5'h04;
  localparam logic [4:0] OFF_COUNTER_TWO = 5'h06;
  localparam logic [4:0] OFF_PRESCALER = 5'h08;
  localparam logic [4:0] OFF_CLOCK_SELECT = 5'h0a;
  localparam logic [4:0] OFF_MODE_CONTROL = 5'h0c;
  localparam logic [4:0] OFF_INT_CONTROL = 5'h0e;
  localparam logic [4:0] OFF_PEND_CLEAR = 5'h10;
  localparam logic [15:0] PEND_CLEAR_READ = 16'h00ff;
  localparam logic [15:0] UNMAPPED_READ = 16'h0000;
  localparam logic [15:0] PRESET_VALUE = 16'hffff;
  localparam logic [7:0] MODE_CONTROL_RESET = 8'h00;
  localparam logic [4:0] PRESCALER_RESET = 5'h00;
  localparam logic [5:0] CLOCK_SELECT_RESET = 6'h00;
  localparam logic [7:0] INT_CONTROL_RESET = 8'h00;
  localparam int MODE_LSB = 0;
  localparam int POL_A_BIT = 2;
  localparam int POL_B_BIT = 3;
  localparam int EN_A_BIT = 4;
  localparam int EN_B_BIT = 5;
  localparam int OUT_A_BIT = 6;
  localparam int GLOBAL_EN_BIT = 7;
  localparam int SEL_ONE_LSB = 0;
  localparam int SEL_TWO_LSB = 3;
  localparam logic [1:0] MODE_PWM_SYSTEM = 2'h0;
  localparam logic [1:0] MODE_DUAL_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_DUAL_TIMER = 2'h2;
  localparam logic [1:0] MODE_SINGLE_CAPTURE = 2'h3;
  localparam logic [2:0] SRC_STOPPED = 3'h0;
  localparam logic [2:0] SRC_PRESCALED = 3'h1;
  localparam logic [2:0] SRC_PIN_EVENT = 3'h2;
  localparam logic [2:0] SRC_PULSE_ACC = 3'h3;
  localparam logic [2:0] SRC_SLOW = 3'h4;
endpackage : dtmc_pkg

// ==== hw/dtmc_prescaler.sv ====
// dtmc_prescaler: divides core_clk by divisor + 1 into a one-cycle tick.
// assumes clear is held while the timer is disabled.
module dtmc_prescaler (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic [4:0] divisor,
  output logic tick
);
  logic [4:0] phase;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      phase <= 5'h00;
    end else if (clear || phase >= divisor) begin
      phase <= 5'h00;
    end else begin
      phase <= phase + 5'h01;
    end
  end

  assign tick = !clear && (phase >= divisor);

  a_tick_divisor: assert property (@(posedge core_clk)
    disable iff (!reset_n)
    tick && !clear ##1 !clear && $stable(divisor) && divisor != 5'h00
    |-> !tick)
    else $error("tick came too soon for divisor");
endmodule : dtmc_prescaler

// ==== hw/dtmc_pin_sync.sv ====
// dtmc_pin_sync: two-flop synchroniser plus edge detect for one pin.
// assumes the pin is asynchronous to core_clk and idles high on the board.
module dtmc_pin_sync (
  input wire logic core_clk,
  input wire logic reset_n,
  input wire logic pinIn,
  input wire logic risePolarity,
  output logic level,
  output logic activeEdge
);
  logic meta;
  logic stage;
  logic prev;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      // idle level after reset, so release shows no false edge
      meta <= 1'b1;
      stage <= 1'b1;
      prev <= 1'b1;
    end else begin
      meta <= pinIn;
      stage <= meta;
      prev <= stage;
    end
  end

  assign level = stage;
  assign activeEdge = risePolarity ? (stage && !prev) : (!stage && prev);
endmodule : dtmc_pin_sync

// ==== tb/dtmc_pin_model.sv ====
// dtmc_pin_model: pins A and B plus the slow tick, as the board drives them.
// assumes calls from the bench right after a rising core_clk edge.
module dtmc_pin_model (
  input wire logic core_clk,
  input wire logic pinAOut,
  input wire logic pinAOe,
  output logic pinAIn,
  output logic pinBIn,
  output logic slowTick
);
  timeunit 1ns;
  timeprecision 1ps;
  logic extA = 1'b1;
  logic extB = 1'b1;
  logic [3:0] slowCnt = 4'h0;
  // released pin falls back to the board level
  assign pinAIn = pinAOe ? pinAOut : extA;
  assign pinBIn = extB;
  assign slowTick = (slowCnt == 4'hf);
  always @(posedge core_clk) begin
    slowCnt <= slowCnt + 4'h1;
  end
  task automatic pulse(input bit onB);
    @(posedge core_clk);
    if (onB) begin
      extB <= 1'b0;
    end else begin
      extA <= 1'b0;
    end
    repeat (4) @(posedge core_clk);
    extA <= 1'b1;
    extB <= 1'b1;
    repeat (4) @(posedge core_clk);
  endtask : pulse
endmodule : dtmc_pin_model

// ==== tb/dtmc_timer_tb.sv ====
// dtmc_timer_tb: register, pin and counting checks of the dual timer.
// assumes one-cycle read latency and the package register map.
module dtmc_timer_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk = 1'b0;
  logic reset_n = 1'b0;
  logic [4:0] regAddr = 5'h00;
  logic [15:0] regWdata = 16'h0000;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic [15:0] regRdata;
  logic pinAIn;
  logic pinAOut;
  logic pinAOe;
  logic pinBIn;
  logic slowTick;
  logic [3:0] pendingFlags;
  logic rdPend = 1'b0;
  logic [15:0] expQ[$];
  string nameQ[$];
  int num_errors = 0;
  int tests_run = 0;
  int seed = 21;
  logic [15:0] v;
  logic [4:0] div;
  logic [4:0] offs [4] = '{5'h00, 5'h06, 5'h02, 5'h04};
  logic [2:0] idle [6] = '{3'h0, 3'h2, 3'h3, 3'h5, 3'h6, 3'h7};

  always #2 core_clk = ~core_clk;

  dtmc_timer dtmc_timer_i (
    .core_clk(core_clk), .reset_n(reset_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .pinAIn(pinAIn), .pinAOut(pinAOut),
    .pinAOe(pinAOe), .pinBIn(pinBIn), .slowTick(slowTick),
    .pendingFlags(pendingFlags)
  );
  dtmc_pin_model dtmc_pin_model_i (
    .core_clk(core_clk), .pinAOut(pinAOut), .pinAOe(pinAOe),
    .pinAIn(pinAIn), .pinBIn(pinBIn), .slowTick(slowTick)
  );

  task automatic check(input string n, input logic [15:0] seen,
                       input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : tally_and_finish

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge core_clk);
    regWrite <= 1'b0;
    @(posedge core_clk);
  endtask : wr

  task automatic rd(input logic [4:0] a, input logic [15:0] e,
                    input string n);
    expQ.push_back(e);
    nameQ.push_back(n);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    @(posedge core_clk);
  endtask : rd

  // direct sample for range checks; no queue entry
  task automatic rdv(input logic [4:0] a, output logic [15:0] r);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge core_clk);
    regRead <= 1'b0;
    #1 r = regRdata;
    @(posedge core_clk);
    @(posedge core_clk);
  endtask : rdv

  task automatic runsrc(input logic [2:0] c, input int n,
                        input logic [15:0] lo, input logic [15:0] hi);
    logic [15:0] r;
    wr(dtmc_pkg::OFF_COUNTER_ONE, 16'h0100);
    wr(dtmc_pkg::OFF_CLOCK_SELECT, {13'h0000, c});
    repeat (n) @(posedge core_clk);
    wr(dtmc_pkg::OFF_CLOCK_SELECT, 16'h0000);
    rdv(dtmc_pkg::OFF_COUNTER_ONE, r);
    check("count", {15'h0000, r >= lo && r <= hi}, 16'h0001);
  endtask : runsrc

  always @(posedge core_clk) begin
    if (rdPend && expQ.size() > 0) begin
      check(nameQ.pop_front(), regRdata, expQ.pop_front());
    end
    rdPend <= regRead;
  end

  initial begin
    #60000;
    num_errors++;
    tally_and_finish();
  end

  initial begin
    repeat (20) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rd(dtmc_pkg::OFF_MODE_CONTROL, 16'h0000, "mode");
    rd(5'h12, dtmc_pkg::UNMAPPED_READ, "unmapped");
    rd(dtmc_pkg::OFF_PEND_CLEAR, dtmc_pkg::PEND_CLEAR_READ, "clr");
    wr(dtmc_pkg::OFF_PRESCALER, 16'h0007);
    rd(dtmc_pkg::OFF_PRESCALER, 16'h0000, "prescaler");
    wr(dtmc_pkg::OFF_INT_CONTROL, 16'h000f);
    rd(dtmc_pkg::OFF_INT_CONTROL, 16'h0000, "pending");
    wr(dtmc_pkg::OFF_MODE_CONTROL, 16'h0082);
    for (int i = 0; i < 4; i++) begin
      v = 16'($random(seed));
      wr(offs[i], v);
      rd(offs[i], v, "word");
    end
    wr(dtmc_pkg::OFF_COUNTER_ONE, 16'h0100);
    wr(dtmc_pkg::OFF_INT_CONTROL, 16'h000f);
    check("flags", {12'h000, pendingFlags}, 16'h000f);
    wr(dtmc_pkg::OFF_INT_CONTROL, 16'h0000);
    rd(dtmc_pkg::OFF_INT_CONTROL, 16'h000f, "pending");
    wr(dtmc_pkg::OFF_PEND_CLEAR, 16'h0005);
    rd(dtmc_pkg::OFF_INT_CONTROL, 16'h000a, "pending");
    wr(dtmc_pkg::OFF_MODE_CONTROL, 16'h0002);
    rd(dtmc_pkg::OFF_INT_CONTROL, 16'h0000, "pending");
    wr(dtmc_pkg::OFF_COUNTER_ONE, 16'h5555);
    rd(dtmc_pkg::OFF_COUNTER_ONE, 16'h0100, "cnt1");
    wr(dtmc_pkg::OFF_CLOCK_SELECT, 16'h0001);
    repeat (40) @(posedge core_clk);
    wr(dtmc_pkg::OFF_CLOCK_SELECT, 16'h0000);
    rd(dtmc_pkg::OFF_COUNTER_ONE, 16'h0100, "cnt1");
    // second reset in mid-run
    reset_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    reset_n <= 1'b1;
    @(posedge core_clk);
    rd(dtmc_pkg::OFF_COUNTER_ONE, 16'h0100, "cnt1");
    rd(dtmc_pkg::OFF_MODE_CONTROL, 16'h0000, "mode");
    wr(dtmc_pkg::OFF_MODE_CONTROL, 16'h0082);
    div = 5'($random(seed)) & 5'h07;
    wr(dtmc_pkg::OFF_PRESCALER, {11'h000, div});
    rd(dtmc_pkg::OFF_PRESCALER, {11'h000, div}, "prescaler");
    foreach (idle[i]) runsrc(idle[i], 40, 16'h0100, 16'h0100);
    runsrc(3'h1, 8 * (div + 1), 16'h00f6, 16'h00f9);
    runsrc(3'h4, 64, 16'h00fb, 16'h00fd);
    wr(dtmc_pkg::OFF_MODE_CONTROL, 16'h00d0);
    check("oe", {15'h0000, pinAOe}, 16'h0001);
    check("out", {15'h0000, pinAOut}, 16'h0001);
    wr(dtmc_pkg::OFF_PRESCALER, 16'h0000);
    wr(dtmc_pkg::OFF_RELOAD_ONE, 16'h0fff);
    wr(dtmc_pkg::OFF_COUNTER_ONE, 16'h0001);
    // tick every cycle: underflow meets the edge taking the mode write
    wr(dtmc_pkg::OFF_CLOCK_SELECT, 16'h0001);
    wr(dtmc_pkg::OFF_MODE_CONTROL, 16'h00d0);
    check("out", {15'h0000, pinAOut}, 16'h0001);
    wr(dtmc_pkg::OFF_COUNTER_ONE, 16'h0000);
    wr(dtmc_pkg::OFF_CLOCK_SELECT, 16'h0000);
    check("out", {15'h0000, pinAOut}, 16'h0000);
    rd(dtmc_pkg::OFF_MODE_CONTROL, 16'h0090, "mode");
    wr(dtmc_pkg::OFF_MODE_CONTROL, 16'h0090);
    check("out", {15'h0000, pinAOut}, 16'h0000);
    wr(dtmc_pkg::OFF_MODE_CONTROL, 16'h0050);
    check("oe", {15'h0000, pinAOe}, 16'h0000);
    wr(dtmc_pkg::OFF_MODE_CONTROL, 16'h00c0);
    check("oe", {15'h0000, pinAOe}, 16'h0000);
    wr(dtmc_pkg::OFF_MODE_CONTROL, 16'h00d1);
    check("oe", {15'h0000, pinAOe}, 16'h0000);
    wr(dtmc_pkg::OFF_COUNTER_ONE, 16'h1234);
    dtmc_pin_model_i.pulse(1'b0);
    rd(dtmc_pkg::OFF_COUNTER_ONE, dtmc_pkg::PRESET_VALUE, "cnt1");
    rd(dtmc_pkg::OFF_RELOAD_ONE, 16'h1234, "rel1");
    rd(dtmc_pkg::OFF_INT_CONTROL, 16'h0002, "pending");
    wr(dtmc_pkg::OFF_MODE_CONTROL, 16'h00a3);
    wr(dtmc_pkg::OFF_COUNTER_TWO, 16'h0042);
    dtmc_pin_model_i.pulse(1'b1);
    rd(dtmc_pkg::OFF_COUNTER_TWO, dtmc_pkg::PRESET_VALUE, "cnt2");
    rd(dtmc_pkg::OFF_RELOAD_TWO, 16'h0042, "rel2");
    wr(dtmc_pkg::OFF_MODE_CONTROL, 16'h00a2);
    wr(dtmc_pkg::OFF_COUNTER_TWO, 16'h0042);
    dtmc_pin_model_i.pulse(1'b1);
    rd(dtmc_pkg::OFF_COUNTER_TWO, 16'h0042, "cnt2");
    wr(dtmc_pkg::OFF_MODE_CONTROL, 16'h00ab);
    wr(dtmc_pkg::OFF_COUNTER_TWO, 16'h0042);
    dtmc_pin_model_i.pulse(1'b1);
    rd(dtmc_pkg::OFF_COUNTER_TWO, dtmc_pkg::PRESET_VALUE, "cnt2");
    // let the monitor take the last read before the verdict
    @(posedge core_clk);
    tally_and_finish();
  end
endmodule : dtmc_timer_tb
